// ### hw/ssx_regs.svh
`ifndef SSX_REGS_SVH
`define SSX_REGS_SVH
// Program counter and ROM geometry
`define SSX_PC_W 15
`define SSX_PAGE_W 8
`define SSX_LAST_PAGE 7'h7F
`define SSX_PC_RST 15'h0000
`define SSX_ACC_RST 8'h00
`define SSX_THB_RST 8'h00
// Cycles taken by a skip that is taken
`define SSX_SKIP_CYCLES 2
`endif

// ### hw/ssx_pkg.sv
package ssx_pkg;
	typedef enum logic [3:0] {
		SSX_OP_NONE = 4'h0,
		SSX_OP_SWAP_ACC = 4'h1,
		SSX_OP_SKZ = 4'h2,
		SSX_OP_MOVSKZ = 4'h3,
		SSX_OP_BITSKZ = 4'h4,
		SSX_OP_TRDC = 4'h5,
		SSX_OP_TRDL = 4'h6,
		SSX_OP_XORA = 4'h7,
		SSX_OP_XOR_MEM = 4'h8,
		SSX_OP_XORI = 4'h9
	} ssx_op_e;
	typedef enum logic [1:0] {
		SSX_ST_EXEC = 2'h1,
		SSX_ST_DUMMY = 2'h2
	} ssx_state_e;
endpackage

// ### hw/ssx_exec.sv
`timescale 1ns/100ps
`include "ssx_regs.svh"
// Summary of operation
// - Swap nibbles of memory byte into accumulator, memory left unchanged.
// - Skip if byte zero: discard prefetch, dummy cycle, 2 cycles; else 1.
// - Copy byte to accumulator, skip next instruction when byte is zero.
// - Skip next instruction when selected bit of memory byte is zero.
// - Current-page table read: low byte to memory, high byte to table high.
// - Last-page table read: low byte to memory, high byte to table high.
// - Accumulator gets accumulator XOR memory; only zero flag updated.
// - Memory gets memory XOR accumulator; zero flag updated.
// - Accumulator gets accumulator XOR immediate; zero flag updated.
module ssx_exec (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire ssx_pkg::ssx_op_e op,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] imm,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] table_pointer,
	input wire logic [15:0] rom_rdata,
	output logic [`SSX_PC_W-1:0] rom_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic [7:0] acc,
	output logic [7:0] table_high_byte_reg,
	output logic zero_flag,
	output logic [`SSX_PC_W-1:0] pc,
	output logic dummy_cycle
);
	// Sequencer state
	ssx_pkg::ssx_state_e state_reg;
	ssx_pkg::ssx_state_e state_next;
	logic [`SSX_PC_W-1:0] pc_reg;
	logic [`SSX_PC_W-1:0] pc_next;

	// Accumulator and zero flag
	logic [7:0] acc_reg;
	logic [7:0] acc_next;
	logic z_reg;
	logic z_next;

	// Table high byte and memory write port
	logic [7:0] thb_reg;
	logic [7:0] thb_next;
	logic [7:0] wdata_reg;
	logic [7:0] wdata_next;
	logic we_reg;
	logic we_next;

	// Shared decode
	logic exec_take;
	logic skip_take;
	logic [7:0] xor_mem;
	logic [7:0] xor_imm;
	logic [7:0] bit_clear;
	logic sel_bit_clear;

	// All-zero test, shared by the two byte-zero skips and the zero flag
	function automatic logic is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	// Both table reads share the write and high byte path
	function automatic logic is_table_op(input ssx_pkg::ssx_op_e o);
		return (o == ssx_pkg::SSX_OP_TRDC) || (o == ssx_pkg::SSX_OP_TRDL);
	endfunction

	// A word offered in the dummy cycle is the discarded one and is ignored
	assign exec_take = instr_valid && (state_reg == ssx_pkg::SSX_ST_EXEC);

	assign xor_mem = acc_reg ^ mem_rdata;
	assign xor_imm = acc_reg ^ imm;

	// One comparator per bit position for the bit-test skip
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			assign bit_clear[gi] = (bit_sel == 3'(gi)) && !mem_rdata[gi];
		end
	endgenerate

	assign sel_bit_clear = |bit_clear;

	// Table address: page bits from current pc or last page, low byte from pointer
	always_comb begin
		if (op == ssx_pkg::SSX_OP_TRDL) begin
			rom_addr = {`SSX_LAST_PAGE, table_pointer};
		end else begin
			rom_addr = {pc_reg[`SSX_PC_W-1:`SSX_PAGE_W], table_pointer};
		end
	end

	// Skip decision for the three skipping instructions
	always_comb begin
		skip_take = 1'h0;
		if (exec_take) begin
			unique case (op)
				ssx_pkg::SSX_OP_SKZ: begin
					skip_take = is_zero(mem_rdata);
				end
				ssx_pkg::SSX_OP_MOVSKZ: begin
					skip_take = is_zero(mem_rdata);
				end
				ssx_pkg::SSX_OP_BITSKZ: begin
					skip_take = sel_bit_clear;
				end
				default: begin
					skip_take = 1'h0;
				end
			endcase
		end
	end

	// Sequencer: pc moves in every executed or dummy cycle
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		unique case (state_reg)
			ssx_pkg::SSX_ST_EXEC: begin
				if (exec_take) begin
					pc_next = pc_reg + `SSX_PC_W'(1);
				end
				if (skip_take) begin
					state_next = ssx_pkg::SSX_ST_DUMMY;
				end
			end
			ssx_pkg::SSX_ST_DUMMY: begin
				// Nothing but the pc moves past the discarded word
				pc_next = pc_reg + `SSX_PC_W'(1);
				state_next = ssx_pkg::SSX_ST_EXEC;
			end
			default: begin
				state_next = ssx_pkg::SSX_ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ssx_pkg::SSX_ST_EXEC;
			pc_reg <= `SSX_PC_RST;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
		end
	end

	// Accumulator and zero flag; dummy cycle leaves both alone
	always_comb begin
		acc_next = acc_reg;
		z_next = z_reg;
		if (exec_take) begin
			unique case (op)
				ssx_pkg::SSX_OP_SWAP_ACC: begin
					acc_next = {mem_rdata[3:0], mem_rdata[7:4]};
				end
				ssx_pkg::SSX_OP_MOVSKZ: begin
					acc_next = mem_rdata;
				end
				ssx_pkg::SSX_OP_XORA: begin
					acc_next = xor_mem;
					z_next = is_zero(xor_mem);
				end
				ssx_pkg::SSX_OP_XOR_MEM: begin
					z_next = is_zero(xor_mem);
				end
				ssx_pkg::SSX_OP_XORI: begin
					acc_next = xor_imm;
					z_next = is_zero(xor_imm);
				end
				default: begin
					acc_next = acc_reg;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= `SSX_ACC_RST;
			z_reg <= 1'h0;
		end else begin
			acc_reg <= acc_next;
			z_reg <= z_next;
		end
	end

	// Memory write port and table high byte; write strobe lasts one cycle
	always_comb begin
		thb_next = thb_reg;
		wdata_next = wdata_reg;
		we_next = 1'h0;
		if (exec_take && is_table_op(op)) begin
			wdata_next = rom_rdata[7:0];
			we_next = 1'h1;
			thb_next = rom_rdata[15:8];
		end
		if (exec_take && (op == ssx_pkg::SSX_OP_XOR_MEM)) begin
			wdata_next = xor_mem;
			we_next = 1'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			thb_reg <= `SSX_THB_RST;
			wdata_reg <= 8'h00;
			we_reg <= 1'h0;
		end else begin
			thb_reg <= thb_next;
			wdata_reg <= wdata_next;
			we_reg <= we_next;
		end
	end

	// Outputs straight from the registers
	assign acc = acc_reg;
	assign table_high_byte_reg = thb_reg;
	assign zero_flag = z_reg;
	assign pc = pc_reg;
	assign mem_wdata = wdata_reg;
	assign mem_we = we_reg;

	// High for the one cycle that replaces the discarded word
	assign dummy_cycle = (state_reg == ssx_pkg::SSX_ST_DUMMY);

endmodule

// ### verif/ssx_exec_props.sv
`timescale 1ns/100ps
module ssx_props (
	input logic clk, arst_n, instr_valid, mem_we, zero_flag, dummy_cycle,
	input ssx_pkg::ssx_op_e op,
	input logic [2:0] bit_sel,
	input logic [7:0] imm, mem_rdata, mem_wdata, acc, table_high_byte_reg,
	input logic [15:0] rom_rdata,
	input logic [14:0] pc
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire t = instr_valid & ~dummy_cycle;
	sequence s_skip; dummy_cycle ##1 !dummy_cycle; endsequence
	property p_swp;
		t && op == 4'h1 |=> {acc[3:0], acc[7:4]} == $past(mem_rdata) && !mem_we;
	endproperty
	a_swp: assert property (p_swp) else $error("swap");
	property p_sz; t && op == 4'h2 && mem_rdata == 8'h00 |=> s_skip; endproperty
	a_sz: assert property (p_sz) else $error("skip");
	property p_nsz; t && op == 4'h2 && mem_rdata != 8'h00 |=> !dummy_cycle; endproperty
	a_nsz: assert property (p_nsz) else $error("no skip");
	property p_pc; t |=> pc == $past(pc) + 15'h1; endproperty
	a_pc: assert property (p_pc) else $error("pc step");
	property p_mov; t && op == 4'h3 |=> acc == $past(mem_rdata) && dummy_cycle == !acc; endproperty
	a_mov: assert property (p_mov) else $error("move");
	property p_bit; t && op == 4'h4 && !mem_rdata[bit_sel] |=> s_skip; endproperty
	a_bit: assert property (p_bit) else $error("bit");
	property p_nbit; t && op == 4'h4 && mem_rdata[bit_sel] |=> !dummy_cycle; endproperty
	a_nbit: assert property (p_nbit) else $error("bit no skip");
	property p_tab; t && op inside {4'h5, 4'h6} |=> mem_we
		&& {table_high_byte_reg, mem_wdata} == $past(rom_rdata); endproperty
	a_tab: assert property (p_tab) else $error("table");
	property p_xa; t && op == 4'h7 |=> acc == ($past(acc) ^ $past(mem_rdata)) && zero_flag == !acc;
	endproperty
	a_xa: assert property (p_xa) else $error("xor acc");
	property p_xm; t && op == 4'h8 |=> mem_we && mem_wdata == ($past(acc) ^ $past(mem_rdata))
		&& zero_flag == !mem_wdata && $stable(acc);
	endproperty
	a_xm: assert property (p_xm) else $error("xor mem");
	property p_xi; t && op == 4'h9 |=> acc == ($past(acc) ^ $past(imm)) && zero_flag == !acc;
	endproperty
	a_xi: assert property (p_xi) else $error("xor imm");
	property p_dm; dummy_cycle |=> $stable(acc) && $stable(zero_flag)
		&& $stable(table_high_byte_reg) && !mem_we && pc == $past(pc) + 15'h1; endproperty
	a_dm: assert property (p_dm) else $error("dummy");
endmodule
bind ssx_exec ssx_props i_props (.clk, .arst_n, .instr_valid, .mem_we, .zero_flag, .dummy_cycle,
	.op, .bit_sel, .imm, .mem_rdata, .mem_wdata, .acc, .table_high_byte_reg, .rom_rdata, .pc);

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, arst_n = 0, v = 0, we, z, dc;
	ssx_pkg::ssx_op_e op = ssx_pkg::SSX_OP_NONE;
	logic [2:0] bs = 0;
	logic [7:0] im = 0, m = 0, tp = 8'h5A, wd, acc, th;
	logic [15:0] rw = 16'hBEEF;
	logic [14:0] ra, pc, rs;
	int errors = 0, check_count = 0;
	always #4 clk = ~clk;
	ssx_exec i_dut (.clk, .arst_n, .instr_valid(v), .op, .bit_sel(bs), .imm(im), .mem_rdata(m),
		.table_pointer(tp), .rom_rdata(rw), .rom_addr(ra), .mem_wdata(wd), .mem_we(we),
		.acc, .table_high_byte_reg(th), .zero_flag(z), .pc, .dummy_cycle(dc));
	task stop_test;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("Error %0t got %h want %h", $time, g, e);
		end
	endtask
	task ex(input ssx_pkg::ssx_op_e o, input logic [7:0] d, i);
		op = o;
		m = d;
		im = i;
		v = 1;
		#2 rs = ra;
		@(posedge clk);
		#1;
	endtask
	task t_xor;
		ex(ssx_pkg::SSX_OP_XORI, 0, 8'h3C); chk({z, acc}, 9'h03C);
		ex(ssx_pkg::SSX_OP_XORA, 8'h3C, 0); chk({z, acc}, 9'h100);
		ex(ssx_pkg::SSX_OP_XORI, 0, 8'hA5); chk({z, acc}, 9'h0A5);
		ex(ssx_pkg::SSX_OP_XOR_MEM, 8'h0F, 0); chk({we, z, wd, acc}, 18'h2AAA5);
	endtask
	task t_swap;
		ex(ssx_pkg::SSX_OP_SWAP_ACC, 8'h12, 0); chk({we, acc}, 9'h021);
	endtask
	task t_table;
		ex(ssx_pkg::SSX_OP_TRDL, 0, 0); chk(rs, 15'h7F5A);
		chk({we, th, wd}, 17'h1BEEF);
		tp = 8'h33;
		rw = 16'h1234;
		ex(ssx_pkg::SSX_OP_TRDC, 0, 0); chk({we, rs}, 16'h8033);
		chk({th, wd}, 16'h1234);
	endtask
	task t_skip;
		ex(ssx_pkg::SSX_OP_SKZ, 0, 0); chk(dc, 1);
		ex(ssx_pkg::SSX_OP_NONE, 0, 0); chk(dc, 0);
		ex(ssx_pkg::SSX_OP_SKZ, 1, 0); chk(dc, 0);
		ex(ssx_pkg::SSX_OP_MOVSKZ, 0, 0); chk({dc, acc}, 9'h100);
		ex(ssx_pkg::SSX_OP_XORI, 0, 8'hFF); chk({dc, z, acc}, 10'h000);
		ex(ssx_pkg::SSX_OP_MOVSKZ, 7, 0); chk({dc, acc}, 9'h007);
	endtask
	task t_bit;
		bs = 3;
		ex(ssx_pkg::SSX_OP_BITSKZ, 8'hF7, 0); chk(dc, 1);
		ex(ssx_pkg::SSX_OP_NONE, 0, 0); chk(dc, 0);
		bs = 2;
		ex(ssx_pkg::SSX_OP_BITSKZ, 8'hF7, 0); chk(dc, 0);
		chk(pc, 15'h0010);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 arst_n = 1;
		t_xor;
		t_swap;
		t_table;
		t_skip;
		t_bit;
		stop_test;
	end
	initial begin
		#5000 errors++;
		stop_test;
	end
endmodule
